// ---- src/sbx_regs.sv ----
// The register offsets and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
module sbx_regs (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // calibration engine (from analog side)
    input wire logic cal_done_i,
    input wire logic cal_fail_i,
    input wire logic [2:0] cal_sel_i,
    input wire logic [2:0] cal_eff_i,
    input wire logic cal_cmp_i,
    // configuration outputs
    output logic [4:0] sys_div_o,
    output logic oscillator_regulator_on_o,
    output logic [1:0] xo_gain_o,
    output logic [5:0] xo_cap_out_o,
    output logic [5:0] xo_cap_in_o,
    output logic [1:0] oscillator_spare_bits_o,
    // interrupt
    output logic irq_o
);
    import sbx_pkg::*;

    // =========================================================
    // input synchronisers
    logic [8:0] sync1_ff;
    logic [8:0] sync2_ff;
    logic done_d_ff;
    logic [8:0] async_in;
    assign async_in = {cal_cmp_i, cal_eff_i, cal_sel_i, cal_fail_i, cal_done_i};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_ff <= 9'h000;
            sync2_ff <= 9'h000;
            done_d_ff <= 1'b0;
        end else if (ce_i) begin
            sync1_ff <= async_in;
            sync2_ff <= sync1_ff;
            done_d_ff <= sync2_ff[0];
        end
    end

    // status word: upper bits are zero
    logic [15:0] bias_calibration_status;
    assign bias_calibration_status = {7'h00, sync2_ff[8], sync2_ff[7:5], sync2_ff[4:2], sync2_ff[1], sync2_ff[0]};

    // =========================================================
    // bus decode
    function automatic logic [31:0] sbx_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic cap_bad(input logic [5:0] c);
        return c > SBX_CAP_MAX;
    endfunction

    // divider codes outside the legal window would push the system clock out of range
    function automatic logic div_bad(input logic [4:0] d);
        return (d < SBX_DIV_MIN) | (d > SBX_DIV_MAX);
    endfunction

    logic ack_ff;
    logic req;
    logic wr;
    logic hit_div;
    logic hit_bias;
    logic hit_xo;
    logic hit_ists;
    logic hit_imask;
    assign req = wb_cyc_i & wb_stb_i & ~ack_ff;
    assign wr = req & wb_we_i;
    assign hit_div = (wb_adr_i == SBX_ADDR_DIV);
    assign hit_bias = (wb_adr_i == SBX_ADDR_BIAS);
    assign hit_xo = (wb_adr_i == SBX_ADDR_XO);
    assign hit_ists = (wb_adr_i == SBX_ADDR_IRQ_STS);
    assign hit_imask = (wb_adr_i == SBX_ADDR_IRQ_MASK);

    // =========================================================
    // registers
    logic [4:0] div_ff;
    logic [18:0] xo_ff;
    logic [3:0] ists_ff;
    logic [3:0] imask_ff;
    logic [31:0] dat_ff;
    logic [31:0] div_wd;
    logic [31:0] xo_wd;
    logic [31:0] ists_wd;
    logic [31:0] imask_wd;
    assign div_wd = sbx_merge({27'h0, div_ff}, wb_dat_i, wb_sel_i);
    assign xo_wd = sbx_merge({13'h0, xo_ff}, wb_dat_i, wb_sel_i);
    assign ists_wd = sbx_merge(32'h0, wb_dat_i, wb_sel_i);
    assign imask_wd = sbx_merge({28'h0, imask_ff}, wb_dat_i, wb_sel_i);

    // events
    logic [3:0] ev;
    logic div_wr_bad;
    logic cap_wr_bad;
    assign div_wr_bad = wr & hit_div & div_bad(div_wd[4:0]);
    assign cap_wr_bad = wr & hit_xo & (cap_bad(xo_wd[13:8]) | cap_bad(xo_wd[5:0]));
    assign ev[SBX_IRQ_DONE] = sync2_ff[0] & ~done_d_ff;
    assign ev[SBX_IRQ_FAIL] = sync2_ff[0] & ~done_d_ff & sync2_ff[1];
    assign ev[SBX_IRQ_BADDIV] = div_wr_bad;
    assign ev[SBX_IRQ_BADCAP] = cap_wr_bad;

    logic [3:0] nxt_ists;
    assign nxt_ists = (ists_ff & ~((wr & hit_ists) ? ists_wd[3:0] : 4'h0)) | ev;

    logic [31:0] rd_mux;
    assign rd_mux = hit_div ? {27'h0, div_ff} :
                    hit_bias ? {16'h0, bias_calibration_status} :
                    hit_xo ? {13'h0, xo_ff} :
                    hit_ists ? {28'h0, ists_ff} :
                    hit_imask ? {28'h0, imask_ff} : 32'h0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_ff <= SBX_DIV_RST;
            xo_ff <= SBX_XO_RST;
            ists_ff <= 4'h0;
            imask_ff <= SBX_IRQ_MASK_RST;
            ack_ff <= 1'b0;
            dat_ff <= 32'h0;
        end else if (ce_i) begin
            ack_ff <= req;
            ists_ff <= nxt_ists;
            if (req) begin
                dat_ff <= rd_mux;
            end
            // out of range divider writes are refused so the clock stays legal
            if (wr & hit_div & ~div_wr_bad) begin
                div_ff <= div_wd[4:0];
            end
            if (wr & hit_xo) begin
                xo_ff <= xo_wd[18:0] & SBX_XO_WMASK;
            end
            if (wr & hit_imask) begin
                imask_ff <= imask_wd[3:0];
            end
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = dat_ff;
    assign irq_o = |(ists_ff & imask_ff);

    assign sys_div_o = div_ff;
    assign oscillator_regulator_on_o = xo_ff[SBX_XO_LDO_BIT];
    assign xo_gain_o = xo_ff[15:14];
    assign xo_cap_out_o = xo_ff[13:8];
    assign xo_cap_in_o = xo_ff[5:0];
    assign oscillator_spare_bits_o = xo_ff[18:17];

    // =========================================================
    // assertions
    sequence s_take;
        ce_i && req;
    endsequence

    sequence s_answer;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    sequence s_bias_rd;
        ce_i && req && hit_bias;
    endsequence

    sequence s_bad_div_wr;
        ce_i && wr && hit_div && div_bad(div_wd[4:0]);
    endsequence

    sequence s_good_div_wr;
        ce_i && wr && hit_div && !div_bad(div_wd[4:0]);
    endsequence

    sequence s_xo_wr;
        ce_i && wr && hit_xo;
    endsequence

    sequence s_done_rise;
        ce_i && sync2_ff[0] && !done_d_ff;
    endsequence

    sequence s_unmapped_rd;
        ce_i && req && !wb_we_i && !(hit_div || hit_bias || hit_xo || hit_ists || hit_imask);
    endsequence


    div_range_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (div_ff >= SBX_DIV_MIN) && (div_ff <= SBX_DIV_MAX))
        else $error("divider out of range");
    div_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
        s_bad_div_wr |=> $stable(div_ff) && ists_ff[SBX_IRQ_BADDIV])
        else $error("bad divider write not refused");
    done_rd_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && req && hit_bias |=> wb_dat_o[0] == $past(sync2_ff[0]))
        else $error("done bit mismatch");
    fail_rd_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && req && hit_bias |=> wb_dat_o[1] == $past(sync2_ff[1]))
        else $error("fail bit mismatch");
    sel_rd_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && req && hit_bias |=> wb_dat_o[4:2] == $past(sync2_ff[4:2]))
        else $error("chosen setting mismatch");
    eff_rd_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && req && hit_bias |=> wb_dat_o[7:5] == $past(sync2_ff[7:5]))
        else $error("applied setting mismatch");
    cmp_raw_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(ce_i) && $past(ce_i, 2) && !$past(rst_i) && !$past(rst_i, 2) |-> bias_calibration_status[8] == $past(cal_cmp_i, 2))
        else $error("comparator not followed");
    ldo_out_a: assert property (@(posedge clk_i)
        $fell(rst_i) |-> oscillator_regulator_on_o && xo_gain_o == 2'h1)
        else $error("oscillator reset wrong");
    cap_reset_a: assert property (@(posedge clk_i)
        $fell(rst_i) |-> xo_cap_out_o == SBX_CAP_RST && xo_cap_in_o == SBX_CAP_RST)
        else $error("capacitance reset wrong");
    rsvd_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && req && hit_bias |=> wb_dat_o[31:9] == 23'h0)
        else $error("reserved bits not zero");

    // register bus
    ack_walk_a: assert property (@(posedge clk_i) disable iff (rst_i)
        s_take ##1 ce_i |-> s_answer)
        else $error("ack not a single cycle answer");

    ack_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");

    dat_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !(ce_i && req) |=> $stable(wb_dat_o))
        else $error("read data changed between accesses");

    ce_freeze_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !ce_i |=> $stable(div_ff) && $stable(xo_ff) && $stable(ists_ff) && $stable(wb_ack_o))
        else $error("state moved while disabled");

    unmapped_rd_a: assert property (@(posedge clk_i) disable iff (rst_i)
        s_unmapped_rd |=> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");

    unmapped_wr_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && wr && !(hit_div || hit_bias || hit_xo || hit_ists || hit_imask) |=>
        $stable(div_ff) && $stable(xo_ff) && $stable(imask_ff))
        else $error("unmapped write changed a register");

    ro_bias_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && wr && (hit_bias || hit_ists) |=> $stable(div_ff) && $stable(xo_ff) && $stable(imask_ff))
        else $error("read only write leaked");

    // divider
    div_store_a: assert property (@(posedge clk_i) disable iff (rst_i)
        s_good_div_wr |=> div_ff == $past(div_wd[4:0]))
        else $error("legal divider write lost");

    div_rd_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && req && hit_div |=> wb_dat_o == {27'h0, $past(div_ff)})
        else $error("divider read mismatch");

    // oscillator control
    xo_store_a: assert property (@(posedge clk_i) disable iff (rst_i)
        s_xo_wr |=> xo_ff == $past(xo_wd[18:0]))
        else $error("oscillator write lost");

    ldo_wr_a: assert property (@(posedge clk_i) disable iff (rst_i)
        s_xo_wr |=> oscillator_regulator_on_o == $past(xo_wd[16]))
        else $error("regulator enable not applied");

    gain_wr_a: assert property (@(posedge clk_i) disable iff (rst_i)
        s_xo_wr |=> xo_gain_o == $past(xo_wd[15:14]))
        else $error("boost count not applied");

    cap_wr_a: assert property (@(posedge clk_i) disable iff (rst_i)
        s_xo_wr |=> xo_cap_in_o == $past(xo_wd[5:0]) && xo_cap_out_o == $past(xo_wd[13:8]))
        else $error("capacitance code not applied");

    spare_store_a: assert property (@(posedge clk_i) disable iff (rst_i)
        s_xo_wr |=> oscillator_spare_bits_o == $past(xo_wd[18:17]))
        else $error("spare bits not stored");

    // interrupt flags
    cap_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && cap_wr_bad |=> ists_ff[SBX_IRQ_BADCAP])
        else $error("bad capacitance write not flagged");

    done_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
        s_done_rise |=> ists_ff[SBX_IRQ_DONE])
        else $error("completion not flagged");

    fail_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
        s_done_rise ##0 sync2_ff[1] |=> ists_ff[SBX_IRQ_FAIL])
        else $error("failure not flagged");

    set_wins_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i |=> (ists_ff & $past(ev)) == $past(ev))
        else $error("event lost to clear");

    sts_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && wr && hit_ists && ev == 4'h0 |=> (ists_ff & $past(ists_wd[3:0])) == 4'h0)
        else $error("status bit not cleared");

    imask_store_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && wr && hit_imask |=> imask_ff == $past(imask_wd[3:0]))
        else $error("mask write lost");

    irq_rise_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && (ev & imask_ff) != 4'h0 && !(wr && hit_imask) |=> irq_o)
        else $error("unmasked event without interrupt");

    ists_rst_a: assert property (@(posedge clk_i)
        $fell(rst_i) |-> ists_ff == 4'h0 && !irq_o && !wb_ack_o)
        else $error("interrupt reset wrong");
endmodule

// ---- src/sbx_pkg.sv ----
package sbx_pkg;
    // =========================================================
    // register map (word aligned byte addresses)
    localparam logic [7:0] SBX_ADDR_DIV = 8'h00;
    localparam logic [7:0] SBX_ADDR_BIAS = 8'h04;
    localparam logic [7:0] SBX_ADDR_XO = 8'h08;
    localparam logic [7:0] SBX_ADDR_IRQ_STS = 8'h0C;
    localparam logic [7:0] SBX_ADDR_IRQ_MASK = 8'h10;
    // =========================================================
    // field layouts and reset values
    localparam logic [4:0] SBX_DIV_RST = 5'h0C;
    localparam logic [4:0] SBX_DIV_MIN = 5'h0A;
    localparam logic [4:0] SBX_DIV_MAX = 5'h0F;
    localparam int SBX_APLL_PRE_DIV = 4;
    localparam int SBX_SYS_MIN_MHZ = 180;
    localparam int SBX_SYS_MAX_MHZ = 333;
    localparam logic [18:0] SBX_XO_RST = 19'h15F1F;
    localparam logic [18:0] SBX_XO_WMASK = 19'h7FFFF;
    localparam logic [5:0] SBX_CAP_MAX = 6'h2F;
    localparam logic [5:0] SBX_CAP_RST = 6'h1F;
    localparam int SBX_XO_LDO_BIT = 16;
    // interrupt status bits
    localparam int SBX_IRQ_DONE = 0;
    localparam int SBX_IRQ_FAIL = 1;
    localparam int SBX_IRQ_BADDIV = 2;
    localparam int SBX_IRQ_BADCAP = 3;
    localparam int SBX_IRQ_W = 4;
    localparam logic [3:0] SBX_IRQ_MASK_RST = 4'h0;
endpackage

// ---- tb/sbx_regs_test.sv ----
`timescale 1ns/1ps
module sbx_regs_test;
    import sbx_pkg::*;
    // =========================================================
    // stimulus and observed signals
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] dat_o;
    logic [31:0] rd;
    logic [31:0] exp_div;
    logic ack, irq, reg_on;
    logic done = 1'b0;
    logic fail = 1'b0;
    logic cmp = 1'b0;
    logic ce = 1'b1;
    logic [31:0] val;
    logic [31:0] divs [5] = '{32'h09, 32'h0A, 32'h0F, 32'h10, 32'h00};
    logic [2:0] sel3 = 3'h0;
    logic [2:0] eff = 3'h0;
    logic [4:0] div;
    logic [1:0] gain, spare;
    logic [5:0] cap_out, cap_in;
    int n_mismatch = 0;
    int checks_done = 0;
    int cycles = 0;
    always #4 clk = ~clk;
    sbx_regs sbx_regs_i (.clk_i(clk), .rst_i(rst), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .cal_done_i(done),
        .cal_fail_i(fail), .cal_sel_i(sel3), .cal_eff_i(eff), .cal_cmp_i(cmp), .sys_div_o(div),
        .oscillator_regulator_on_o(reg_on), .xo_gain_o(gain), .xo_cap_out_o(cap_out), .xo_cap_in_o(cap_in),
        .oscillator_spare_bits_o(spare), .irq_o(irq));
    // =========================================================
    // tasks
    task automatic results;
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    // classic cycle: hold until ack is sampled high, take data at that edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        #1;
    endtask
    task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(name, exp, rd);
    endtask
    // =========================================================
    // timeout
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            results();
        end
    end
    // =========================================================
    // tests
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rdchk("div", SBX_ADDR_DIV, 32'h0C);
        rdchk("xo", SBX_ADDR_XO, 32'h15F1F);
        chk("xo outs", 32'h15F1F, {13'h0, spare, reg_on, gain, cap_out, 2'h0, cap_in});
        rdchk("bias", SBX_ADDR_BIAS, 32'h0);
        rdchk("mask", SBX_ADDR_IRQ_MASK, 32'h0);
        exp_div = 32'h0C;
        foreach (divs[k]) begin
            val = divs[k];
            if (val[4:0] >= SBX_DIV_MIN && val[4:0] <= SBX_DIV_MAX) exp_div = val;
            wb(1'b1, SBX_ADDR_DIV, val);
            rdchk("div", SBX_ADDR_DIV, exp_div);
            chk("div out", exp_div, {27'h0, div});
        end
        wb(1'b1, SBX_ADDR_DIV, 32'h0C);
        rdchk("sts", SBX_ADDR_IRQ_STS, 32'h4);
        wb(1'b1, SBX_ADDR_XO, 32'hFFFFFFFF);
        rdchk("xo all", SBX_ADDR_XO, 32'h7FFFF);
        chk("xo outs", 32'h7FFFF, {13'h0, spare, reg_on, gain, cap_out, 2'h3, cap_in});
        rdchk("sts", SBX_ADDR_IRQ_STS, 32'hC);
        wb(1'b1, SBX_ADDR_XO, 32'h2F2F);
        rdchk("xo", SBX_ADDR_XO, 32'h2F2F);
        chk("regulator", 32'h0, {31'h0, reg_on});
        wb(1'b1, 8'h14, 32'hFFFFFFFF);
        rdchk("unmapped", 8'h14, 32'h0);
        @(posedge clk);
        sel3 <= 3'h5;
        eff <= 3'h3;
        cmp <= 1'b1;
        fail <= 1'b1;
        repeat (4) @(posedge clk);
        done <= 1'b1;
        repeat (4) @(posedge clk);
        rdchk("bias", SBX_ADDR_BIAS, 32'h177);
        wb(1'b1, SBX_ADDR_BIAS, 32'h0);
        rdchk("bias ro", SBX_ADDR_BIAS, 32'h177);
        @(posedge clk);
        cmp <= 1'b0;
        repeat (4) @(posedge clk);
        rdchk("bias cmp", SBX_ADDR_BIAS, 32'h077);
        rdchk("sts", SBX_ADDR_IRQ_STS, 32'hF);
        chk("irq masked", 32'h0, {31'h0, irq});
        wb(1'b1, SBX_ADDR_IRQ_MASK, 32'h2);
        chk("irq", 32'h1, {31'h0, irq});
        wb(1'b1, SBX_ADDR_IRQ_STS, 32'h2);
        chk("irq clr", 32'h0, {31'h0, irq});
        rdchk("sts", SBX_ADDR_IRQ_STS, 32'hD);
        @(posedge clk);
        ce <= 1'b0;
        cmp <= 1'b1;
        repeat (4) @(posedge clk);
        ce <= 1'b1;
        rdchk("bias frozen", SBX_ADDR_BIAS, 32'h077);
        results();
    end
endmodule
